// [hw/gio_pin_ctrl.sv]
// gio_pin_ctrl: general pin control with AXI4-Lite registers, sleep hold, wake
module gio_pin_ctrl #(
  parameter int unsigned NPINS = gio_pkg::NPINS_DEF
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // axi4-lite slave
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // peripheral (secondary function) side
  input  wire logic [NPINS-1:0] periph_en,
  input  wire logic [NPINS-1:0] periph_dir,
  input  wire logic [NPINS-1:0] periph_out,
  // pins
  input  wire logic [NPINS-1:0] general_io_pin_i,
  output logic [NPINS-1:0]      general_io_pin_o,
  output logic [NPINS-1:0]      general_io_pin_oe_n,
  output logic [NPINS-1:0]      pin_pullup_resistor_en,
  output logic [NPINS-1:0]      pin_in_sync,
  output logic                  wake_event
);
  // the two-wire pins sit at fixed indices and the register word is 32 bits
  if (NPINS < 6 || NPINS > 32)
  begin : g_bad_npins
    $error("gio_pin_ctrl: NPINS must be 6..32");
  end

  // ---------------------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------------------
  logic [31:0] dir_q, out_q, pull_q, irqen_q, wake_q, ctrl_q;
  logic        aw_q, w_q, bv_q, rv_q;
  logic [31:0] rdata_q;
  logic [1:0]  bresp_q, rresp_q;
  gio_pkg::gio_wreq_t wreq_q;
  logic        sleep_q;
  wire         wake_any;

  wire aw_take = s_axi_awvalid && !aw_q && !bv_q;
  wire w_take  = s_axi_wvalid && !w_q && !bv_q;
  wire wr_go   = (aw_q || aw_take) && (w_q || w_take) && !bv_q;
  wire [7:0]  wa = aw_q ? wreq_q.addr : s_axi_awaddr;
  wire [31:0] wd = w_q ? wreq_q.data : s_axi_wdata;
  wire [3:0]  ws = w_q ? wreq_q.strb : s_axi_wstrb;
  wire [31:0] wmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
  wire [31:0] pin_mask = (NPINS == 32) ? 32'hFFFF_FFFF
                       : ((32'h1 << NPINS) - 32'h1);
  wire wr_dir   = wr_go && wa == gio_pkg::OFS_DIR;
  wire wr_out   = wr_go && wa == gio_pkg::OFS_OUT;
  wire wr_pull  = wr_go && wa == gio_pkg::OFS_PULL;
  wire wr_irqen = wr_go && wa == gio_pkg::OFS_IRQEN;
  wire wr_ctrl  = wr_go && wa == gio_pkg::OFS_CTRL;
  wire wr_wake  = wr_go && wa == gio_pkg::OFS_WAKE;
  wire wr_in    = wr_go && wa == gio_pkg::OFS_IN;
  wire wr_ok    = wr_dir | wr_out | wr_pull | wr_irqen | wr_ctrl | wr_wake
                | wr_in;
  wire [31:0] wnew_dir  = ((dir_q & ~wmask) | (wd & wmask)) & pin_mask;
  wire [31:0] wnew_out  = ((out_q & ~wmask) | (wd & wmask)) & pin_mask;
  wire [31:0] wnew_pull = ((pull_q & ~wmask) | (wd & wmask)) & pin_mask;
  wire [31:0] wnew_irq  = ((irqen_q & ~wmask) | (wd & wmask)) & pin_mask;
  wire [31:0] wnew_ctrl = ((ctrl_q & ~wmask) | (wd & wmask)) & 32'h0000_0003;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q   <= 1'b0;
      w_q    <= 1'b0;
      bv_q   <= 1'b0;
      bresp_q <= gio_pkg::RESP_OKAY;
      wreq_q <= '0;
    end
    else
    begin
      aw_q <= wr_go ? 1'b0 : (aw_q | aw_take);
      w_q  <= wr_go ? 1'b0 : (w_q | w_take);
      if (aw_take)
        wreq_q.addr <= s_axi_awaddr;
      if (w_take)
      begin
        wreq_q.data <= s_axi_wdata;
        wreq_q.strb <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        bv_q    <= 1'b1;
        bresp_q <= wr_ok ? gio_pkg::RESP_OKAY : gio_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        bv_q <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_q && !bv_q && aresetn;
  assign s_axi_wready  = !w_q && !bv_q && aresetn;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = bresp_q;

  // read path
  wire ar_take = s_axi_arvalid && !rv_q;
  logic [31:0] rd_mux;
  logic        rd_ok;
  always_comb
  begin
    rd_ok  = 1'b1;
    rd_mux = gio_pkg::RST_ZERO;
    unique case (s_axi_araddr)
      gio_pkg::OFS_DIR:   rd_mux = dir_q;
      gio_pkg::OFS_OUT:   rd_mux = out_q;
      gio_pkg::OFS_PULL:  rd_mux = pull_q;
      gio_pkg::OFS_IN:    rd_mux = 32'(pin_in_sync);
      gio_pkg::OFS_IRQEN: rd_mux = irqen_q;
      gio_pkg::OFS_CTRL:  rd_mux = ctrl_q;
      gio_pkg::OFS_WAKE:  rd_mux = wake_q;
      default:            rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rv_q    <= 1'b0;
      rdata_q <= gio_pkg::RST_ZERO;
      rresp_q <= gio_pkg::RESP_OKAY;
    end
    else if (ar_take)
    begin
      rv_q    <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_ok ? gio_pkg::RESP_OKAY : gio_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      rv_q <= 1'b0;
  end

  assign s_axi_arready = !rv_q && aresetn;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // ---------------------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------------------
  // pull enables stay writable in sleep: they never touch drive state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dir_q   <= gio_pkg::RST_DIR;
      out_q   <= gio_pkg::RST_OUT;
      pull_q  <= gio_pkg::RST_PULL & pin_mask;
      irqen_q <= gio_pkg::RST_ZERO;
      ctrl_q  <= gio_pkg::RST_ZERO;
    end
    else
    begin
      if (wr_dir)
        dir_q <= wnew_dir;
      if (wr_out)
        out_q <= wnew_out;
      if (wr_pull)
        pull_q <= wnew_pull;
      if (wr_irqen)
        irqen_q <= wnew_irq;
      if (wr_ctrl)
        ctrl_q <= wnew_ctrl;
      else if (wake_any)
        ctrl_q[gio_pkg::CTRL_SLEEP] <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // input synchroniser, two-wire glitch filter
  // ---------------------------------------------------------------------------
  localparam int unsigned FILTW = $clog2(gio_pkg::FILT_LEN + 1);
  logic [NPINS-1:0] meta_q, sync_q, prev_q;
  wire  [NPINS-1:0] filt_q;
  logic [1:0]       twf_q;
  logic [FILTW-1:0] fcnt_q [2];
  wire  [1:0]       tw_sync = {sync_q[gio_pkg::TWB_IDX],
                               sync_q[gio_pkg::TWA_IDX]};
  wire twowire = ctrl_q[gio_pkg::CTRL_TWOWIRE];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= general_io_pin_i;
      sync_q <= meta_q;
    end
  end

  // a level must hold FILT_LEN cycles before it passes
  always_ff @(posedge aclk)
  begin
    for (int k = 0; k < 2; k++)
    begin
      if (!aresetn)
      begin
        fcnt_q[k] <= '0;
        twf_q[k]  <= 1'b0;
      end
      else if (!twowire || tw_sync[k] == twf_q[k])
      begin
        fcnt_q[k] <= '0;
        twf_q[k]  <= twowire ? twf_q[k] : tw_sync[k];
      end
      else if (fcnt_q[k] == FILTW'(gio_pkg::FILT_LEN - 1))
      begin
        fcnt_q[k] <= '0;
        twf_q[k]  <= tw_sync[k];
      end
      else
        fcnt_q[k] <= fcnt_q[k] + FILTW'(1);
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++)
    begin : g_filt
      if (gi == gio_pkg::TWA_IDX)
      begin : g_twa
        assign filt_q[gi] = twf_q[0];
      end
      else if (gi == gio_pkg::TWB_IDX)
      begin : g_twb
        assign filt_q[gi] = twf_q[1];
      end
      else
      begin : g_pass
        assign filt_q[gi] = sync_q[gi];
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // pin drive, sleep hold, wake
  // ---------------------------------------------------------------------------
  wire [NPINS-1:0] eff_dir = (periph_en & periph_dir)
                           | (~periph_en & dir_q[NPINS-1:0]);
  wire [NPINS-1:0] eff_out = (periph_en & periph_out)
                           | (~periph_en & out_q[NPINS-1:0]);
  // only pins that are not driving can wake the block
  wire [NPINS-1:0] chg     = (filt_q ^ prev_q) & irqen_q[NPINS-1:0]
                           & general_io_pin_oe_n;
  wire             sleep_req = ctrl_q[gio_pkg::CTRL_SLEEP];
  logic [NPINS-1:0] tw_mask;
  logic [NPINS-1:0] drv_dir, drv_out;

  always_comb
  begin
    tw_mask = '0;
    tw_mask[gio_pkg::TWA_IDX] = twowire;
    tw_mask[gio_pkg::TWB_IDX] = twowire;
    // open drain: drive only while the level is low
    drv_dir = (eff_dir & ~tw_mask) | (tw_mask & eff_dir & ~eff_out);
    drv_out = eff_out & ~tw_mask;
  end

  assign wake_any = sleep_q && (|chg);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      general_io_pin_oe_n    <= '1;
      general_io_pin_o       <= '0;
      pin_pullup_resistor_en <= '1;
      prev_q                 <= '0;
      pin_in_sync            <= '0;
      wake_event             <= 1'b0;
      wake_q                 <= gio_pkg::RST_ZERO;
      sleep_q                <= 1'b0;
    end
    else
    begin
      sleep_q <= sleep_req && !wake_any;
      if (!sleep_q)
      begin
        general_io_pin_oe_n <= ~drv_dir;
        general_io_pin_o    <= drv_out;
      end
      pin_pullup_resistor_en <= pull_q[NPINS-1:0];
      prev_q      <= filt_q;
      pin_in_sync <= filt_q;
      wake_event  <= wake_any;
      // latched wake cause; new events win over a clear
      wake_q <= (wr_wake ? (wake_q & ~(wd & wmask)) : wake_q)
              | (wake_any ? 32'(chg) : 32'h0);
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  reset_hiz_a: assert property (@(posedge aclk)
    !aresetn |=> general_io_pin_oe_n == '1)
    else $error("pins driven after reset");
  pull_reset_a: assert property (@(posedge aclk)
    !aresetn ##1 aresetn |-> pin_pullup_resistor_en == '1)
    else $error("pull not enabled out of reset");
  sleep_hold_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    sleep_q && $past(sleep_q) |-> $stable(general_io_pin_oe_n)
    && $stable(general_io_pin_o))
    else $error("pin changed during sleep");
  periph_dir_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    !sleep_q && !twowire && periph_en[0] |=>
    general_io_pin_oe_n[0] == !$past(periph_dir[0]))
    else $error("peripheral direction not applied");
  gen_dir_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    !sleep_q && !periph_en[1] |=>
    general_io_pin_oe_n[1] == !$past(dir_q[1]))
    else $error("general direction not applied");
  open_drain_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    $past(twowire) |-> general_io_pin_o[gio_pkg::TWA_IDX] == 1'b0
    && general_io_pin_o[gio_pkg::TWB_IDX] == 1'b0)
    else $error("two-wire pin driven high");
  wake_gen_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    wake_any |=> wake_event ##1 !sleep_q)
    else $error("wake event not raised");
  pull_indep_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    wr_pull && !wr_dir && !wr_out |=> $stable(dir_q) && $stable(out_q))
    else $error("pull write disturbed drive");
  sync_delay_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    !twowire ##1 !twowire [*2] |-> filt_q[0] == $past(general_io_pin_i[0], 2))
    else $error("synchroniser depth wrong");
  wake_cov_c: cover property (@(posedge aclk) disable iff (!aresetn)
    sleep_q ##[1:20] wake_event);
  tw_cov_c: cover property (@(posedge aclk) disable iff (!aresetn)
    twowire && !general_io_pin_oe_n[gio_pkg::TWA_IDX]);
  periph_cov_c: cover property (@(posedge aclk) disable iff (!aresetn)
    periph_en[0] && !general_io_pin_oe_n[0]);
endmodule : gio_pin_ctrl

// [inc/gio_pkg.sv]
// gio_pkg: constants, register map and carrier types for the pin control block
// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------
package gio_pkg;
  localparam int unsigned NPINS_DEF  = 20;
  localparam int unsigned TWA_IDX    = 4;
  localparam int unsigned TWB_IDX    = 5;
  localparam int unsigned FILT_LEN   = 3;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // register byte offsets
  localparam logic [7:0] OFS_DIR    = 8'h00;
  localparam logic [7:0] OFS_OUT    = 8'h04;
  localparam logic [7:0] OFS_PULL   = 8'h08;
  localparam logic [7:0] OFS_IN     = 8'h0C;
  localparam logic [7:0] OFS_IRQEN  = 8'h10;
  localparam logic [7:0] OFS_CTRL   = 8'h14;
  localparam logic [7:0] OFS_WAKE   = 8'h18;
  // control register fields
  localparam int unsigned CTRL_TWOWIRE = 0;
  localparam int unsigned CTRL_SLEEP   = 1;
  // reset values
  localparam logic [31:0] RST_DIR  = 32'h0000_0000;
  localparam logic [31:0] RST_OUT  = 32'h0000_0000;
  localparam logic [31:0] RST_PULL = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } gio_wreq_t;

  typedef enum logic [1:0] {
    GIO_AWAKE  = 2'b00,
    GIO_ASLEEP = 2'b01
  } gio_pwr_t;
endpackage : gio_pkg

// [verif/gio_board_model.sv]
// gio_board_model: board circuitry behind the pins, pulls and drivers
module gio_board_model #(
  parameter int unsigned NPINS = 20
) (
  input  wire logic             aclk,
  input  wire logic [NPINS-1:0] drv_o,
  input  wire logic [NPINS-1:0] drv_oe_n,
  input  wire logic [NPINS-1:0] pull_en,
  input  wire logic [NPINS-1:0] ext_en,
  input  wire logic [NPINS-1:0] ext_val,
  output logic [NPINS-1:0]      pin_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // wire resolution
  // ---------------------------------------------------------------
  logic [NPINS-1:0] last_q = '0;
  always_comb
  begin
    for (int i = 0; i < NPINS; i++)
    begin
      if (!drv_oe_n[i])
        pin_lvl[i] = drv_o[i];
      else if (ext_en[i])
        pin_lvl[i] = ext_val[i];
      else if (pull_en[i])
        pin_lvl[i] = 1'b1;
      // floating wire: toggles so that no stale level passes as valid
      else
        pin_lvl[i] = ~last_q[i];
    end
  end
  always @(posedge aclk)
    last_q <= pin_lvl;
endmodule : gio_board_model

// [verif/tb_general_io_pin_control.sv]
// tb_general_io_pin_control: self-checking bench for the pin control block
module tb_general_io_pin_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned NP = gio_pkg::NPINS_DEF;
  localparam int unsigned TA = gio_pkg::TWA_IDX;
  localparam int unsigned TB = gio_pkg::TWB_IDX;
  localparam int unsigned WK = 9;
  localparam logic [31:0] MASK = (32'h1 << NP) - 32'h1;
  localparam logic [31:0] ANLG = 32'h0006_000F;
  logic          aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic          s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic          s_axi_bvalid, s_axi_arready, s_axi_rvalid, wake_event;
  logic [7:0]    s_axi_awaddr, s_axi_araddr;
  logic [31:0]   s_axi_wdata, s_axi_rdata;
  logic [1:0]    s_axi_bresp, s_axi_rresp;
  logic [NP-1:0] periph_en, periph_dir, periph_out, pin_lvl, ext_en, ext_val;
  logic [NP-1:0] general_io_pin_o, general_io_pin_oe_n, pin_in_sync;
  logic [NP-1:0] pin_pullup_resistor_en;
  logic [31:0]   m_dir, m_out, m_pull, m_irq, m_ctrl, m_wake, sv_oen, sv_o;
  int            n_fail, tests_run;

  gio_pin_ctrl #(.NPINS(NP)) gio_pin_ctrl_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .periph_en, .periph_dir, .periph_out,
    .general_io_pin_i(pin_lvl), .general_io_pin_o, .general_io_pin_oe_n,
    .pin_pullup_resistor_en, .pin_in_sync, .wake_event
  );
  gio_board_model #(.NPINS(NP)) gio_board_model_inst (
    .aclk, .drv_o(general_io_pin_o), .drv_oe_n(general_io_pin_oe_n),
    .pull_en(pin_pullup_resistor_en), .ext_en, .ext_val, .pin_lvl
  );

  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // ---------------------------------------------------------------
  // reference model and checks
  // ---------------------------------------------------------------
  function automatic logic [31:0] e_oen();
    logic [31:0] r;
    r = ~((32'(periph_en) & 32'(periph_dir)) | (~32'(periph_en) & m_dir));
    r = r & MASK;
    if (m_ctrl[gio_pkg::CTRL_TWOWIRE])
    begin
      r[TA] = ~(m_dir[TA] & ~m_out[TA]);
      r[TB] = ~(m_dir[TB] & ~m_out[TB]);
    end
    return r;
  endfunction : e_oen

  function automatic logic [31:0] e_o();
    logic [31:0] r;
    r = (32'(periph_en) & 32'(periph_out)) | (~32'(periph_en) & m_out);
    if (m_ctrl[gio_pkg::CTRL_TWOWIRE])
    begin
      r[TA] = 1'b0;
      r[TB] = 1'b0;
    end
    return r;
  endfunction : e_o

  task automatic report_and_stop();
    if (n_fail == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (e !== g)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic hang();
    chk("handshake", 32'h1, 32'h0);
    report_and_stop();
  endtask : hang

  task automatic chk_pins();
    chk("pin_oe_n", e_oen(), 32'(general_io_pin_oe_n));
    chk("pin_o", e_o(), 32'(general_io_pin_o));
    chk("pull_en", m_pull, 32'(pin_pullup_resistor_en));
  endtask : chk_pins

  task automatic mreset();
    m_dir = 32'h0;
    m_out = 32'h0;
    m_pull = MASK;
    m_irq = 32'h0;
    m_ctrl = 32'h0;
    m_wake = 32'h0;
  endtask : mreset

  // ---------------------------------------------------------------
  // axi4-lite master
  // ---------------------------------------------------------------
  task automatic wreg(input logic [7:0] a, input logic [31:0] dd);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (n > 40)
        hang();
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(gio_pkg::RESP_OKAY), 32'(s_axi_bresp));
    case (a)
      gio_pkg::OFS_DIR:   m_dir = dd & MASK;
      gio_pkg::OFS_OUT:   m_out = dd & MASK;
      gio_pkg::OFS_PULL:  m_pull = dd & MASK;
      gio_pkg::OFS_IRQEN: m_irq = dd & MASK;
      gio_pkg::OFS_CTRL:  m_ctrl = dd & 32'h3;
      gio_pkg::OFS_WAKE:  m_wake = m_wake & ~dd;
      default: ;
    endcase
  endtask : wreg

  task automatic rreg(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (n > 40)
        hang();
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
  endtask : rreg

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    logic [7:0]  ra [7];
    logic [31:0] d;
    logic [31:0] v;
    int          n;
    void'($urandom(32'hFB15F2FF));
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    s_axi_wdata = 32'h0;
    {periph_en, periph_dir, periph_out, ext_en, ext_val} = '0;
    n_fail = 0;
    tests_run = 0;
    mreset();
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    chk_pins();
    ra = '{gio_pkg::OFS_DIR, gio_pkg::OFS_OUT, gio_pkg::OFS_PULL,
           gio_pkg::OFS_IRQEN, gio_pkg::OFS_CTRL, gio_pkg::OFS_WAKE, 8'h1C};
    foreach (ra[i])
      rreg(ra[i], (i == 2) ? MASK : 32'h0,
           (i == 6) ? gio_pkg::RESP_SLVERR : gio_pkg::RESP_OKAY);
    repeat (4)
    begin
      wreg(gio_pkg::OFS_DIR, $urandom());
      wreg(gio_pkg::OFS_OUT, $urandom());
      periph_en <= NP'($urandom());
      periph_dir <= NP'($urandom());
      periph_out <= NP'($urandom());
      repeat (2) @(posedge aclk);
      chk_pins();
      wreg(gio_pkg::OFS_PULL, $urandom());
      repeat (2) @(posedge aclk);
      chk_pins();
    end
    ext_en <= '1;
    ext_val <= NP'($urandom());
    repeat (5) @(posedge aclk);
    v = (~e_oen() & e_o()) | (e_oen() & 32'(ext_val));
    chk("in_sync", v, 32'(pin_in_sync));
    rreg(gio_pkg::OFS_IN, v, gio_pkg::RESP_OKAY);
    // two-wire pair: every dir/out combination on both pins
    periph_en <= '0;
    wreg(gio_pkg::OFS_CTRL, 32'h1);
    for (int k = 0; k < 4; k++)
    begin
      d = $urandom();
      {d[TB], d[TA]} = 2'(k);
      wreg(gio_pkg::OFS_DIR, d);
      {d[TA], d[TB]} = 2'(k);
      wreg(gio_pkg::OFS_OUT, d);
      repeat (2) @(posedge aclk);
      chk_pins();
    end
    wreg(gio_pkg::OFS_DIR, 32'h0);
    repeat (8) @(posedge aclk);
    v = 32'(pin_in_sync);
    ext_val[TB] <= ~ext_val[TB];
    @(posedge aclk);
    ext_val[TB] <= ~ext_val[TB];
    repeat (8)
    begin
      @(posedge aclk);
      chk("filtered", v, 32'(pin_in_sync));
    end
    wreg(gio_pkg::OFS_CTRL, 32'h0);
    // analog-shared pins go input with pull off before any analog use
    wreg(gio_pkg::OFS_PULL, MASK & ~ANLG);
    d = $urandom() & ~ANLG & ~(32'h1 << WK);
    wreg(gio_pkg::OFS_DIR, d);
    wreg(gio_pkg::OFS_OUT, $urandom());
    wreg(gio_pkg::OFS_IRQEN, 32'h1 << WK);
    rreg(gio_pkg::OFS_IRQEN, m_irq, gio_pkg::RESP_OKAY);
    sv_oen = e_oen();
    sv_o = e_o();
    wreg(gio_pkg::OFS_CTRL, 32'h2);
    wreg(gio_pkg::OFS_DIR, (d ^ MASK) & ~ANLG & ~(32'h1 << WK));
    wreg(gio_pkg::OFS_OUT, ~m_out);
    repeat (3) @(posedge aclk);
    chk("hold_oe_n", sv_oen, 32'(general_io_pin_oe_n));
    chk("hold_o", sv_o, 32'(general_io_pin_o));
    ext_val[WK] <= ~ext_val[WK];
    n = 0;
    while (wake_event !== 1'b1 && n < 12)
    begin
      @(posedge aclk);
      n++;
    end
    chk("wake", 32'h1, 32'(wake_event));
    if (wake_event !== 1'b1)
      report_and_stop();
    m_ctrl = 32'h0;
    m_wake = 32'h1 << WK;
    rreg(gio_pkg::OFS_CTRL, 32'h0, gio_pkg::RESP_OKAY);
    rreg(gio_pkg::OFS_WAKE, m_wake, gio_pkg::RESP_OKAY);
    wreg(gio_pkg::OFS_WAKE, m_wake);
    rreg(gio_pkg::OFS_WAKE, 32'h0, gio_pkg::RESP_OKAY);
    chk_pins();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    mreset();
    chk_pins();
    chk("wake_rst", 32'h0, 32'(wake_event));
    aresetn <= 1'b1;
    report_and_stop();
  end
endmodule : tb_general_io_pin_control
